// ---- irq_regs_pkg.sv ----
package irq_regs_pkg;

    // ****************************************
    // Register map and reset values
    // ****************************************
    localparam logic [7:0] OFF_BASE_PRIO = 8'hb8;
    localparam logic [7:0] OFF_EXT_EN_A = 8'he6;
    localparam logic [7:0] OFF_EXT_EN_B = 8'he7;
    localparam logic [7:0] OFF_EXT_PRIO_A = 8'hf6;
    localparam logic [7:0] RST_BASE_PRIO = 8'h80;
    localparam logic [7:0] RST_EXT = 8'h00;
    localparam logic [7:0] WMASK_BASE_PRIO = 8'h7f;
    localparam logic [7:0] WMASK_EXT_EN_B = 8'h3f;
    localparam logic [7:0] WMASK_FULL = 8'hff;
    localparam logic [7:0] READ_UNMAPPED = 8'h00;

    // ****************************************
    // Bit addressing
    // ****************************************
    localparam int BIT_POS_W = 3;
    localparam int BIT_GRP_W = 5;
    localparam logic [BIT_GRP_W-1:0] BIT_GRP_BASE_PRIO = OFF_BASE_PRIO[7:BIT_POS_W];
    localparam logic [BIT_POS_W-1:0] BIT_POS_UNUSED = 3'h7;

    // ****************************************
    // Sources, in natural polling order
    // ****************************************
    localparam int NUM_SRC = 21;
    typedef logic [4:0] src_idx_t;
    typedef logic [NUM_SRC-1:0] src_vec_t;
    localparam src_idx_t SRC_TIMER3 = 5'h0e;
    localparam logic [4:0] IDX_NONE = 5'h00;

    typedef struct packed {
        logic unused_one;
        logic serial_periph_prio;
        logic timer2_prio;
        logic uart_zero_prio;
        logic timer1_prio;
        logic extpin1_prio;
        logic timer0_prio;
        logic extpin0_prio;
    } base_prio_t;

    typedef struct packed {
        logic timer3_mask;
        logic comparator1_mask;
        logic comparator0_mask;
        logic counter_array_mask;
        logic conv_done_mask;
        logic conv_window_mask;
        logic usb_function_mask;
        logic smbus_zero_mask;
    } ext_enable_a_t;

    typedef struct packed {
        logic timer3_prio;
        logic comparator1_prio;
        logic comparator0_prio;
        logic counter_array_prio;
        logic conv_done_prio;
        logic conv_window_prio;
        logic usb_function_prio;
        logic smbus_zero_prio;
    } ext_prio_a_t;

    typedef struct packed {
        logic [1:0] unused_zero;
        logic timer5_mask;
        logic timer4_mask;
        logic smbus_one_mask;
        logic reserved_bit;
        logic uart_one_mask;
        logic bus_power_sense_mask;
    } ext_enable_b_t;

    typedef struct packed {
        logic timer5_high_overflow;
        logic timer5_low_overflow;
        logic timer4_high_overflow;
        logic timer4_low_overflow;
        logic smbus_one_req;
        logic uart_one_req;
        logic bus_power_sense_req;
        logic timer3_high_overflow;
        logic timer3_low_overflow;
        logic comparator1_rise_flag;
        logic comparator1_fall_flag;
        logic comparator0_rise_flag;
        logic comparator0_fall_flag;
        logic counter_array_req;
        logic conversion_done_flag;
        logic window_compare_flag;
        logic usb_function_req;
        logic smbus_zero_req;
        logic serial_periph_req;
        logic timer2_overflow;
        logic uart_zero_req;
        logic timer1_overflow;
        logic extpin1_pend;
        logic timer0_overflow;
        logic extpin0_pend;
    } src_flags_t;

    typedef struct packed {
        logic valid;
        logic high;
        src_idx_t index;
    } irq_present_t;

endpackage : irq_regs_pkg

// ---- irq_first_set.sv ----
`timescale 1ns/1ns
`default_nettype none
module irq_first_set (
    input wire irq_regs_pkg::src_vec_t vec,
    output logic found,
    output irq_regs_pkg::src_idx_t idx
);
    // Lowest index wins, matching the natural polling order
    always_comb begin
        found = 1'b0;
        idx = irq_regs_pkg::IDX_NONE;
        for (int i = irq_regs_pkg::NUM_SRC - 1; i >= 0; i--) begin
            if (vec[i]) begin
                found = 1'b1;
                idx = irq_regs_pkg::src_idx_t'(i);
            end
        end
    end
endmodule : irq_first_set
`default_nettype wire

// ---- irq_enable_priority_regs.sv ----
// Functional notes
// [R01] Bit 7 of the base priority register always reads one and ignores writes.
// [R02] Base priority bits 6..0 set priority of SPI, timer 2, UART0, timer 1, ext 1, timer 0, ext 0.
// [R03] A priority bit of zero means low level and one means high level for its source.
// [R04] First extended enable bits 7..0 mask timer 3, cmp 1, cmp 0, PCA, conv done, window, USB, SMBus 0.
// [R05] With timer 3 enabled either overflow flag requests; disabled, neither does.
// [R06] A comparator enable passes its rise or fall flag; clear masks both.
// [R07] The conversion-done enable gates the conversion-done flag.
// [R08] The window-compare enable gates the window-compare flag.
// [R09] The USB and SMBus 0 enables gate every request of their peripheral.
// [R10] First extended priority bits 7..0 set priority of the same eight sources in that order.
// [R11] Second extended enable bits 5,4,3,1,0 mask timer 5, timer 4, SMBus 1, UART1, bus power sense.
// [R12] Second extended enable bits 7:6 read zero and ignore writes; software writes zero to bit 2.
// [R13] With timer 4 or timer 5 enabled either of its overflow flags requests.
// [R14] The base priority register decodes on every page and accepts single-bit access.
// [R15] The global gate at zero blocks every source; at one each follows its own enable.
// [R16] Enabled pending sources are presented; high may preempt low service, never the reverse.
`timescale 1ns/1ns
`default_nettype none
module irq_enable_priority_regs (
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire logic [7:0] sfr_addr,
    input wire logic [7:0] sfr_wdata,
    input wire logic sfr_wr,
    input wire logic sfr_rd,
    output logic [7:0] sfr_rdata_q,
    output logic sfr_hit_q,
    input wire logic [7:0] bit_addr,
    input wire logic bit_wdata,
    input wire logic bit_wr,
    input wire logic bit_rd,
    output logic bit_rdata_q,
    input wire irq_regs_pkg::src_flags_t src_flags,
    input wire logic [6:0] base_enable,
    input wire logic global_irq_gate,
    input wire logic [7:0] ext_prio_b,
    input wire logic isr_enter,
    input wire logic isr_exit,
    output irq_regs_pkg::irq_present_t irq_q,
    output irq_regs_pkg::base_prio_t base_prio_q,
    output irq_regs_pkg::ext_enable_a_t ext_enable_a_q,
    output irq_regs_pkg::ext_enable_b_t ext_enable_b_q,
    output irq_regs_pkg::ext_prio_a_t ext_prio_a_q
);

    // ****************************************
    // Helpers
    // ****************************************
    function automatic logic [7:0] wmerge(input logic [7:0] old_v, input logic [7:0] new_v,
                                          input logic [7:0] mask);
        wmerge = (old_v & ~mask) | (new_v & mask);
    endfunction : wmerge

    function automatic logic [7:0] bit_set(input logic [7:0] old_v,
                                           input logic [irq_regs_pkg::BIT_POS_W-1:0] pos,
                                           input logic val);
        logic [7:0] r;
        r = old_v;
        r[pos] = val;
        bit_set = r;
    endfunction : bit_set

    // ****************************************
    // Decode
    // ****************************************
    logic hit_base;
    logic hit_en_a;
    logic hit_en_b;
    logic hit_prio_a;
    logic bit_hit_base;
    logic [irq_regs_pkg::BIT_POS_W-1:0] bit_pos;

    // Page select is ignored on purpose: these registers sit in every page
    // [R14] all-page decode
    assign hit_base = (sfr_addr == irq_regs_pkg::OFF_BASE_PRIO);
    assign hit_en_a = (sfr_addr == irq_regs_pkg::OFF_EXT_EN_A);
    assign hit_en_b = (sfr_addr == irq_regs_pkg::OFF_EXT_EN_B);
    assign hit_prio_a = (sfr_addr == irq_regs_pkg::OFF_EXT_PRIO_A);
    assign bit_pos = bit_addr[irq_regs_pkg::BIT_POS_W-1:0];
    assign bit_hit_base = (bit_addr[7:irq_regs_pkg::BIT_POS_W] == irq_regs_pkg::BIT_GRP_BASE_PRIO);

    // ****************************************
    // Registers
    // ****************************************
    // Byte write wins over a bit write in the same cycle
    // [R01] unused bit held at one
    // [R02] base priority storage
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            base_prio_q <= irq_regs_pkg::RST_BASE_PRIO;
        end else if (sfr_wr && hit_base) begin
            base_prio_q <= wmerge(base_prio_q, sfr_wdata, irq_regs_pkg::WMASK_BASE_PRIO);
        end else if (bit_wr && bit_hit_base && bit_pos != irq_regs_pkg::BIT_POS_UNUSED) begin
            // [R14] single-bit write
            base_prio_q <= bit_set(base_prio_q, bit_pos, bit_wdata);
        end
    end

    // [R04] first enable storage
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            ext_enable_a_q <= irq_regs_pkg::RST_EXT;
        end else if (sfr_wr && hit_en_a) begin
            ext_enable_a_q <= sfr_wdata;
        end
    end

    // Reserved bit 2 is stored as written; software keeps it zero
    // [R11] second enable storage
    // [R12] top bits locked zero
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            ext_enable_b_q <= irq_regs_pkg::RST_EXT;
        end else if (sfr_wr && hit_en_b) begin
            ext_enable_b_q <= wmerge(ext_enable_b_q, sfr_wdata, irq_regs_pkg::WMASK_EXT_EN_B);
        end
    end

    // [R10] first priority storage
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            ext_prio_a_q <= irq_regs_pkg::RST_EXT;
        end else if (sfr_wr && hit_prio_a) begin
            ext_prio_a_q <= wmerge(ext_prio_a_q, sfr_wdata, irq_regs_pkg::WMASK_FULL);
        end
    end

    // ****************************************
    // Read path
    // ****************************************
    // Unmapped reads answer zero with hit low so other SFR blocks can be ORed in
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            sfr_rdata_q <= irq_regs_pkg::READ_UNMAPPED;
            sfr_hit_q <= 1'b0;
        end else if (sfr_rd) begin
            sfr_hit_q <= hit_base | hit_en_a | hit_en_b | hit_prio_a;
            if (hit_base) begin
                sfr_rdata_q <= base_prio_q;
            end else if (hit_en_a) begin
                sfr_rdata_q <= ext_enable_a_q;
            end else if (hit_en_b) begin
                sfr_rdata_q <= ext_enable_b_q;
            end else if (hit_prio_a) begin
                sfr_rdata_q <= ext_prio_a_q;
            end else begin
                sfr_rdata_q <= irq_regs_pkg::READ_UNMAPPED;
            end
        end else begin
            sfr_hit_q <= 1'b0;
        end
    end

    // [R14] single-bit read
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            bit_rdata_q <= 1'b0;
        end else if (bit_rd) begin
            bit_rdata_q <= bit_hit_base & base_prio_q[bit_pos];
        end
    end

    // ****************************************
    // Request gating and priority
    // ****************************************
    irq_regs_pkg::src_vec_t raw_vec;
    irq_regs_pkg::src_vec_t en_vec;
    irq_regs_pkg::src_vec_t prio_vec;
    irq_regs_pkg::src_vec_t pend_vec;
    irq_regs_pkg::src_vec_t hi_vec;
    irq_regs_pkg::src_vec_t lo_vec;
    logic hi_found;
    logic lo_found;
    irq_regs_pkg::src_idx_t hi_idx;
    irq_regs_pkg::src_idx_t lo_idx;
    logic in_high_q;
    logic in_low_q;

    // [R05] timer 3 either flag
    // [R06] comparator rise or fall
    // [R13] timer 4 and 5 either flag
    assign raw_vec = {src_flags.timer5_high_overflow | src_flags.timer5_low_overflow,
                      src_flags.timer4_high_overflow | src_flags.timer4_low_overflow,
                      src_flags.smbus_one_req, 1'b0, src_flags.uart_one_req,
                      src_flags.bus_power_sense_req,
                      src_flags.timer3_high_overflow | src_flags.timer3_low_overflow,
                      src_flags.comparator1_rise_flag | src_flags.comparator1_fall_flag,
                      src_flags.comparator0_rise_flag | src_flags.comparator0_fall_flag,
                      src_flags.counter_array_req, src_flags.conversion_done_flag,
                      src_flags.window_compare_flag, src_flags.usb_function_req,
                      src_flags.smbus_zero_req, src_flags.serial_periph_req,
                      src_flags.timer2_overflow, src_flags.uart_zero_req,
                      src_flags.timer1_overflow, src_flags.extpin1_pend,
                      src_flags.timer0_overflow, src_flags.extpin0_pend};

    // [R07] conversion-done mask
    // [R08] window mask
    // [R09] USB and SMBus 0 mask
    // [R11] second enable masks
    assign en_vec = {ext_enable_b_q.timer5_mask, ext_enable_b_q.timer4_mask,
                     ext_enable_b_q.smbus_one_mask, 1'b0, ext_enable_b_q.uart_one_mask,
                     ext_enable_b_q.bus_power_sense_mask, ext_enable_a_q, base_enable};

    // [R03] one bit selects high level
    assign prio_vec = {ext_prio_b[5:3], 1'b0, ext_prio_b[1:0], ext_prio_a_q,
                       base_prio_q[6:0]};

    // [R15] global gate
    assign pend_vec = raw_vec & en_vec & {irq_regs_pkg::NUM_SRC{global_irq_gate}};
    assign hi_vec = pend_vec & prio_vec;
    assign lo_vec = pend_vec & ~prio_vec;

    irq_first_set u_pick_high (
        .vec(hi_vec),
        .found(hi_found),
        .idx(hi_idx)
    );

    irq_first_set u_pick_low (
        .vec(lo_vec),
        .found(lo_found),
        .idx(lo_idx)
    );

    // High service blocks everything; low service blocks only low requests
    // [R16] present and preempt
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            irq_q <= '0;
        end else if (hi_found && !in_high_q) begin
            irq_q <= '{valid: 1'b1, high: 1'b1, index: hi_idx};
        end else if (lo_found && !in_high_q && !in_low_q) begin
            irq_q <= '{valid: 1'b1, high: 1'b0, index: lo_idx};
        end else begin
            irq_q <= '0;
        end
    end

    // Exit retires the innermost level; a same-cycle enter is applied afterwards
    // [R16] service nesting
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            in_high_q <= 1'b0;
            in_low_q <= 1'b0;
        end else begin
            if (isr_enter && irq_q.valid && irq_q.high) begin
                in_high_q <= 1'b1;
            end else if (isr_exit && in_high_q) begin
                in_high_q <= 1'b0;
            end
            if (isr_enter && irq_q.valid && !irq_q.high) begin
                in_low_q <= 1'b1;
            end else if (isr_exit && !in_high_q) begin
                in_low_q <= 1'b0;
            end
        end
    end

    // ****************************************
    // Checks
    // ****************************************
    irq_regs_pkg::src_vec_t en_d1;
    irq_regs_pkg::src_vec_t prio_d1;
    irq_regs_pkg::src_vec_t hi_d1;
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            en_d1 <= '0;
            prio_d1 <= '0;
            hi_d1 <= '0;
        end else begin
            en_d1 <= en_vec & {irq_regs_pkg::NUM_SRC{global_irq_gate}};
            prio_d1 <= prio_vec;
            hi_d1 <= hi_vec;
        end
    end

    base_bit_one_a: assert property (@(posedge ref_clk) disable iff (!rst_b) // [R01]
        base_prio_q.unused_one == 1'b1) else $error("base priority bit 7 not one");

    base_write_a: assert property (@(posedge ref_clk) disable iff (!rst_b) // [R02]
        sfr_wr && hit_base |=> base_prio_q[6:0] == $past(sfr_wdata[6:0]))
        else $error("base priority write lost");

    level_select_a: assert property (@(posedge ref_clk) disable iff (!rst_b) // [R03]
        irq_q.valid |-> irq_q.high == prio_d1[irq_q.index])
        else $error("presented level does not match priority bit");

    enable_a_write_a: assert property (@(posedge ref_clk) disable iff (!rst_b) // [R04]
        sfr_wr && hit_en_a |=> ext_enable_a_q == $past(sfr_wdata))
        else $error("first enable write lost");

    timer3_gate_a: assert property (@(posedge ref_clk) disable iff (!rst_b) // [R05]
        irq_q.valid && irq_q.index == irq_regs_pkg::SRC_TIMER3 |->
        $past(ext_enable_a_q.timer3_mask && (src_flags.timer3_low_overflow ||
        src_flags.timer3_high_overflow))) else $error("timer 3 presented while masked");

    masked_source_a: assert property (@(posedge ref_clk) disable iff (!rst_b) // [R09]
        irq_q.valid |-> en_d1[irq_q.index]) else $error("masked source presented");

    prio_a_write_a: assert property (@(posedge ref_clk) disable iff (!rst_b) // [R10]
        sfr_wr && hit_prio_a |=> ext_prio_a_q == $past(sfr_wdata))
        else $error("first priority write lost");

    enable_b_write_a: assert property (@(posedge ref_clk) disable iff (!rst_b) // [R11]
        sfr_wr && hit_en_b |=> ext_enable_b_q[5:0] == $past(sfr_wdata[5:0]))
        else $error("second enable write lost");

    enable_b_top_a: assert property (@(posedge ref_clk) disable iff (!rst_b) // [R12]
        ext_enable_b_q.unused_zero == 2'b00) else $error("second enable top bits set");

    bit_write_a: assert property (@(posedge ref_clk) disable iff (!rst_b) // [R14]
        bit_wr && bit_hit_base && !(sfr_wr && hit_base) &&
        bit_pos != irq_regs_pkg::BIT_POS_UNUSED |=>
        base_prio_q[$past(bit_pos)] == $past(bit_wdata)) else $error("bit write lost");

    gate_off_a: assert property (@(posedge ref_clk) disable iff (!rst_b) // [R15]
        !global_irq_gate |=> !irq_q.valid) else $error("request passed closed gate");

    high_first_a: assert property (@(posedge ref_clk) disable iff (!rst_b) // [R16]
        irq_q.valid && !irq_q.high |-> hi_d1 == '0 && !$past(in_low_q))
        else $error("low request presented over high or during low service");

endmodule : irq_enable_priority_regs
`default_nettype wire

// ---- core_model.sv ----
`timescale 1ns/1ns
`default_nettype none
module core_model (
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire irq_regs_pkg::irq_present_t irq_q,
    input wire logic go,
    input wire logic [7:0] hold,
    output logic isr_enter,
    output logic isr_exit
);
    logic [1:0] depth_q;
    logic [7:0] cnt_q;
    logic [1:0] gap_q;

    // Entry answers in the cycle irq_q is shown, since the design samples both together
    // nested entry
    assign isr_enter = go && irq_q.valid && gap_q == 2'h0 && depth_q != 2'h2;

    // ****************************************
    // Vectoring and return
    // ****************************************
    // Gap blocks entry for the three cycles after an enter or exit, while irq_q may still show the old service level
    // nested return
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            isr_exit <= 1'b0;
            depth_q <= 2'h0;
            cnt_q <= 8'h00;
            gap_q <= 2'h0;
        end else begin
            isr_exit <= 1'b0;
            if (gap_q != 2'h0) begin
                gap_q <= gap_q - 2'h1;
            end
            if (isr_enter) begin
                depth_q <= depth_q + 2'h1;
                cnt_q <= hold;
                gap_q <= 2'h3;
            end else if (depth_q != 2'h0) begin
                if (cnt_q <= 8'h01) begin
                    isr_exit <= 1'b1;
                    depth_q <= depth_q - 2'h1;
                    cnt_q <= hold;
                    gap_q <= 2'h3;
                end else begin
                    cnt_q <= cnt_q - 8'h01;
                end
            end
        end
    end
endmodule : core_model
`default_nettype wire

// ---- irq_enable_priority_regs_test.sv ----
`timescale 1ns/1ns
`default_nettype none
module irq_enable_priority_regs_test;
    typedef struct packed {
        logic [7:0] a;
        logic [7:0] d;
        logic [7:0] rd;
        logic hit;
    } row_t;
    logic ref_clk = 1'b0;
    logic rst_b = 1'b0;
    logic [7:0] sfr_addr = 8'h00;
    logic [7:0] sfr_wdata = 8'h00;
    logic sfr_wr = 1'b0;
    logic sfr_rd = 1'b0;
    logic [7:0] sfr_rdata_q;
    logic sfr_hit_q;
    logic [7:0] bit_addr = 8'h00;
    logic bit_wdata = 1'b0;
    logic bit_wr = 1'b0;
    logic bit_rd = 1'b0;
    logic bit_rdata_q;
    irq_regs_pkg::src_flags_t src_flags = '0;
    logic [6:0] base_enable = 7'h00;
    logic global_irq_gate = 1'b1;
    logic [7:0] ext_prio_b = 8'h3b;
    logic isr_enter;
    logic isr_exit;
    logic go = 1'b0;
    logic [7:0] hold = 8'h28;
    irq_regs_pkg::irq_present_t irq_q;
    irq_regs_pkg::base_prio_t base_prio_q;
    irq_regs_pkg::ext_enable_a_t ext_enable_a_q;
    irq_regs_pkg::ext_enable_b_t ext_enable_b_q;
    irq_regs_pkg::ext_prio_a_t ext_prio_a_q;
    int n_errors = 0;
    int n_checks = 0;
    logic [20:0] en;
    logic [4:0] idx;
    logic [7:0] grp;
    // Bit 2 of the second enable row is written as 0b, bits 7:6 as ones
    row_t rows [8] = '{'{8'hb8, 8'h7f, 8'hff, 1'b1}, '{8'hb8, 8'h00, 8'h80, 1'b1},
        '{8'he6, 8'h55, 8'h55, 1'b1}, '{8'he6, 8'haa, 8'haa, 1'b1},
        '{8'he7, 8'hfb, 8'h3b, 1'b1}, '{8'he7, 8'hc0, 8'h00, 1'b1},
        '{8'hf6, 8'ha5, 8'ha5, 1'b1}, '{8'h3c, 8'h5a, 8'h00, 1'b0}};
    // Source number for each flag bit, lowest bit first
    logic [4:0] exp_idx [25] = '{5'h00, 5'h01, 5'h02, 5'h03, 5'h04, 5'h05, 5'h06, 5'h07,
        5'h08, 5'h09, 5'h0a, 5'h0b, 5'h0c, 5'h0c, 5'h0d, 5'h0d, 5'h0e, 5'h0e, 5'h0f,
        5'h10, 5'h12, 5'h13, 5'h13, 5'h14, 5'h14};

    always #25 ref_clk = ~ref_clk;

    irq_enable_priority_regs uut (.ref_clk, .rst_b, .sfr_addr, .sfr_wdata, .sfr_wr, .sfr_rd,
        .sfr_rdata_q, .sfr_hit_q, .bit_addr, .bit_wdata, .bit_wr, .bit_rd, .bit_rdata_q,
        .src_flags, .base_enable, .global_irq_gate, .ext_prio_b, .isr_enter, .isr_exit,
        .irq_q, .base_prio_q, .ext_enable_a_q, .ext_enable_b_q, .ext_prio_a_q);
    core_model partner (.ref_clk, .rst_b, .irq_q, .go, .hold, .isr_enter, .isr_exit);

    // ****************************************
    // Bus cycles and comparison
    // ****************************************
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("unexpected at %0t ns: got 0x%h, expected 0x%h", $time, got, exp);
        end
    endtask : chk

    task automatic sfr_acc(input logic wr, input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        #2;
        sfr_addr = a;
        sfr_wdata = d;
        sfr_wr = wr;
        sfr_rd = !wr;
        @(posedge ref_clk);
        #2;
        sfr_wr = 1'b0;
        sfr_rd = 1'b0;
    endtask : sfr_acc

    task automatic bit_acc(input logic wr, input logic [7:0] a, input logic d);
        @(posedge ref_clk);
        #2;
        bit_addr = a;
        bit_wdata = d;
        bit_wr = wr;
        bit_rd = !wr;
        @(posedge ref_clk);
        #2;
        bit_wr = 1'b0;
        bit_rd = 1'b0;
    endtask : bit_acc

    // With until_valid set, returns just after the edge at which irq_q shows a request, or after n cycles
    task automatic settle(input int n, input logic until_valid);
        repeat (n) begin
            @(posedge ref_clk);
            #2;
            if (until_valid && irq_q.valid === 1'b1) break;
        end
    endtask : settle

    task automatic tally_and_finish;
        $display("checks %0d, mismatches %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : tally_and_finish

    // ****************************************
    // Test sequence
    // ****************************************
    initial begin
        grp = {irq_regs_pkg::BIT_GRP_BASE_PRIO, 3'h0};
        repeat (6) @(posedge ref_clk);
        #2;
        rst_b = 1'b1;
        foreach (rows[i]) begin
            sfr_acc(1'b1, rows[i].a, rows[i].d);
            sfr_acc(1'b0, rows[i].a, 8'h00);
            chk(32'({sfr_hit_q, sfr_rdata_q}), 32'({rows[i].hit, rows[i].rd}));
        end
        sfr_acc(1'b1, irq_regs_pkg::OFF_EXT_PRIO_A, 8'h00);
        $display("register table done");
        // Each source alone, enabled only by its own bit, then by all the others
        for (int i = 0; i < 25; i++) begin
            idx = exp_idx[i];
            en = 21'h1 << idx;
            src_flags = irq_regs_pkg::src_flags_t'(25'h1 << i);
            base_enable = en[6:0];
            sfr_acc(1'b1, irq_regs_pkg::OFF_EXT_EN_A, en[14:7]);
            sfr_acc(1'b1, irq_regs_pkg::OFF_EXT_EN_B, {2'b00, en[20:15] & 6'h3b});
            settle(2, 1'b0);
            chk(32'(irq_q), {25'h0, 1'b1, idx >= 5'h0f, idx});
            base_enable = ~en[6:0];
            sfr_acc(1'b1, irq_regs_pkg::OFF_EXT_EN_A, ~en[14:7]);
            sfr_acc(1'b1, irq_regs_pkg::OFF_EXT_EN_B, {2'b00, ~en[20:15] & 6'h3b});
            settle(2, 1'b0);
            chk(32'(irq_q.valid), 32'h0);
        end
        $display("source sweep done");
        src_flags = '1;
        base_enable = 7'h7f;
        global_irq_gate = 1'b0;
        sfr_acc(1'b1, irq_regs_pkg::OFF_EXT_EN_A, 8'hff);
        sfr_acc(1'b1, irq_regs_pkg::OFF_EXT_EN_B, 8'h3b);
        settle(2, 1'b0);
        chk(32'(irq_q.valid), 32'h0);
        global_irq_gate = 1'b1;
        settle(2, 1'b0);
        chk(32'(irq_q), 32'h0000_006f);
        sfr_acc(1'b1, irq_regs_pkg::OFF_EXT_PRIO_A, 8'h80);
        settle(2, 1'b0);
        chk(32'(irq_q), 32'h0000_006e);
        bit_acc(1'b1, grp, 1'b1);
        settle(2, 1'b0);
        chk(32'(irq_q), 32'h0000_0060);
        bit_acc(1'b1, grp | 8'h07, 1'b0);
        bit_acc(1'b0, grp | 8'h07, 1'b0);
        chk(32'(bit_rdata_q), 32'h1);
        sfr_acc(1'b0, irq_regs_pkg::OFF_BASE_PRIO, 8'h00);
        chk(32'(sfr_rdata_q), 32'h81);
        $display("priority done");
        // Slow core: low service, high preempts, both return in order
        src_flags = '0;
        sfr_acc(1'b1, irq_regs_pkg::OFF_EXT_EN_A, 8'h00);
        sfr_acc(1'b1, irq_regs_pkg::OFF_EXT_EN_B, 8'h00);
        sfr_acc(1'b1, irq_regs_pkg::OFF_EXT_PRIO_A, 8'h00);
        sfr_acc(1'b1, irq_regs_pkg::OFF_BASE_PRIO, 8'h01);
        go = 1'b1;
        src_flags.timer0_overflow = 1'b1;
        settle(10, 1'b0);
        chk(32'(irq_q.valid), 32'h0);
        src_flags.extpin0_pend = 1'b1;
        settle(10, 1'b1);
        chk(32'(irq_q), 32'h0000_0060);
        src_flags.extpin0_pend = 1'b0;
        settle(200, 1'b1);
        chk(32'(irq_q), 32'h0000_0041);
        go = 1'b0;
        src_flags = '0;
        $display("nesting done");
        rst_b = 1'b0;
        settle(2, 1'b0);
        chk({base_prio_q, ext_enable_a_q, ext_enable_b_q, ext_prio_a_q}, 32'h8000_0000);
        chk(32'(irq_q), 32'h0);
        rst_b = 1'b1;
        $display("reset done");
        tally_and_finish();
    end

    initial begin
        #400_000;
        n_errors++;
        tally_and_finish();
    end
endmodule : irq_enable_priority_regs_test
`default_nettype wire
